// >>> core/dvf_consts.svh
// Constants for the verify and track format engine.
// Included by the package and by dvf_engine; definitions only.
`ifndef DVF_CONSTS_SVH
`define DVF_CONSTS_SVH
`define DVF_CRC_PRESET 16'hFFFF
`define DVF_CRC_POLY   16'h1021
`define DVF_MFM_GAP    8'h4E
`define DVF_FM_GAP     8'hFF
`define DVF_SYNC_BYTE  8'h00
`define DVF_IAM_SYNC   8'hC2
`define DVF_AM_SYNC    8'hA1
`define DVF_IAM        8'hFC
`define DVF_IDAM       8'hFE
`define DVF_DAM        8'hFB
`define DVF_DDAM       8'hF8
`define DVF_MFM_GAP4A  16'h0050
`define DVF_FM_GAP4A   16'h0028
`define DVF_MFM_SYNC   16'h000C
`define DVF_FM_SYNC    16'h0006
`define DVF_MFM_GAP1   16'h0032
`define DVF_FM_GAP1    16'h001A
`define DVF_MFM_GAP2   16'h0016
`define DVF_PERP_GAP2  16'h0029
`define DVF_FM_GAP2    16'h000B
`define DVF_AMS_LEN    16'h0003
`define DVF_MARK_LEN   16'h0001
`define DVF_ID_LEN     16'h0004
`define DVF_CRC_LEN    16'h0002
`define DVF_SEC_BASE   16'h0080
`define DVF_GAP4B_LEN  16'hFFFF
`define DVF_ZERO_TOTAL 9'h100
`define DVF_ID_NEED    5'h04
`endif

// >>> core/dvf_pkg.sv
// Types shared by the verify and track format engine.
// Assumes dvf_consts.svh is on the include path.
package dvf_pkg;
  `include "dvf_consts.svh"
  typedef enum logic [1:0] {
    REC_MFM  = 2'h0,
    REC_FM   = 2'h1,
    REC_PERP = 2'h2
  } dvf_rec_e;
  typedef enum logic [4:0] {
    F_IDLE  = 5'h00, F_WIDX  = 5'h01, F_GAP4A = 5'h02,
    F_SYNC0 = 5'h03, F_IAMS  = 5'h04, F_IAM   = 5'h05,
    F_GAP1  = 5'h06, F_SYNC1 = 5'h07, F_IDAMS = 5'h08,
    F_IDAM  = 5'h09, F_ID    = 5'h0A, F_IDCRC = 5'h0B,
    F_GAP2  = 5'h0C, F_SYNC2 = 5'h0D, F_DAMS  = 5'h0E,
    F_DAM   = 5'h0F, F_DATA  = 5'h10, F_DCRC  = 5'h11,
    F_GAP3  = 5'h12, F_GAP4B = 5'h13
  } dvf_fmt_e;
  typedef enum logic [0:0] {
    V_IDLE = 1'h0,
    V_RUN  = 1'h1
  } dvf_vfy_e;
endpackage : dvf_pkg

// >>> core/dvf_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a fill count.
// Single clock, synchronous active-low reset; depth a power of two.
`timescale 1ns/1ps
module dvf_fifo #(
  parameter int W  = 8,
  parameter int D  = 16,
  parameter int AW = $clog2(D)
) (
  input  wire logic          i_mclk,
  input  wire logic          i_rst_n,
  input  wire logic          i_in_valid,
  output logic               o_in_ready,
  input  wire logic [W-1:0]  i_in_data,
  output logic               o_out_valid,
  input  wire logic          i_out_ready,
  output logic [W-1:0]       o_out_data,
  output logic [AW:0]        o_count
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0]   cnt_q;
  logic          push, pop;

  // Handshakes; full and empty come straight from the count
  assign o_in_ready  = (cnt_q != (AW+1)'(D));
  assign o_out_valid = (cnt_q != '0);
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_data  = mem[rp_q];
  assign o_count     = cnt_q;

  // Storage has no reset; only pointers and count matter
  always_ff @(posedge i_mclk) begin
    if (push) mem[wp_q] <= i_in_data;
  end

  // Pointers and count
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dvf_fifo

// >>> core/dvf_engine.sv
// Verify and track format execution engine of a floppy controller.
// Assumes a byte-level read stream from the data separator and a
// write serializer that pulses i_byte_en once per byte slot.
`timescale 1ns/1ps
`include "dvf_consts.svh"
module dvf_engine #(
  parameter int ID_DEPTH = 16,
  parameter int ID_W     = 8
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  // Command parameters
  input  wire logic              i_vfy_start,
  input  wire logic              i_fmt_start,
  input  wire dvf_pkg::dvf_rec_e i_mode,
  input  wire logic              i_count_limit_on,
  input  wire logic              i_multi_track,
  input  wire logic [7:0]        i_sector_total,
  input  wire logic [7:0]        i_last_sector,
  input  wire logic [7:0]        i_start_sector,
  input  wire logic [7:0]        i_sectors_per_side,
  input  wire logic              i_head,
  input  wire logic [2:0]        i_size_code,
  input  wire logic [7:0]        i_gap_length,
  input  wire logic [7:0]        i_fill_byte,
  input  wire logic              i_deleted,
  // Host ID byte stream
  input  wire logic              i_id_valid,
  output logic                   o_id_ready,
  input  wire logic [ID_W-1:0]   i_id_data,
  output logic                   o_id_req,
  // Drive side
  input  wire logic              i_index_pulse,
  input  wire logic              i_rd_valid,
  input  wire logic [7:0]        i_rd_data,
  input  wire logic              i_rd_eof,
  input  wire logic [7:0]        i_rd_sector,
  input  wire logic              i_byte_en,
  output logic                   o_wr_gate,
  output logic [7:0]             o_wr_data,
  output logic                   o_wr_mark,
  output logic                   o_side,
  // Status
  input  wire logic              i_int_clr,
  output logic                   o_int,
  output logic                   o_vfy_busy,
  output logic                   o_fmt_busy,
  output logic                   o_vfy_ok,
  output logic                   o_crc_err,
  output logic                   o_underrun
);
  import dvf_pkg::*;

  // One byte of CCITT CRC, MSB first; shared by verify and format
  function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                          input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ b[i]) ? ({r[14:0], 1'b0} ^ `DVF_CRC_POLY)
                         : {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc_upd

  // Segment order; FM has no pre-mark sync bytes
  function automatic dvf_fmt_e seg_next(input dvf_fmt_e s,
                                        input logic fm,
                                        input logic last);
    case (s)
      F_GAP4A: return F_SYNC0;
      F_SYNC0: return fm ? F_IAM : F_IAMS;
      F_IAMS:  return F_IAM;
      F_IAM:   return F_GAP1;
      F_GAP1:  return F_SYNC1;
      F_SYNC1: return fm ? F_IDAM : F_IDAMS;
      F_IDAMS: return F_IDAM;
      F_IDAM:  return F_ID;
      F_ID:    return F_IDCRC;
      F_IDCRC: return F_GAP2;
      F_GAP2:  return F_SYNC2;
      F_SYNC2: return fm ? F_DAM : F_DAMS;
      F_DAMS:  return F_DAM;
      F_DAM:   return F_DATA;
      F_DATA:  return F_DCRC;
      F_DCRC:  return F_GAP3;
      F_GAP3:  return last ? F_GAP4B : F_SYNC1;
      default: return s;
    endcase
  endfunction : seg_next

  // Byte count of each segment in the selected layout
  function automatic logic [15:0] seg_len(input dvf_fmt_e s,
                                          input logic fm,
                                          input logic perp,
                                          input logic [2:0] sz,
                                          input logic [7:0] gap_length);
    case (s)
      F_GAP4A: return fm ? `DVF_FM_GAP4A : `DVF_MFM_GAP4A;
      F_SYNC0, F_SYNC1, F_SYNC2:
               return fm ? `DVF_FM_SYNC : `DVF_MFM_SYNC;
      F_IAMS, F_IDAMS, F_DAMS: return `DVF_AMS_LEN;
      F_GAP1:  return fm ? `DVF_FM_GAP1 : `DVF_MFM_GAP1;
      F_ID:    return `DVF_ID_LEN;
      F_IDCRC, F_DCRC: return `DVF_CRC_LEN;
      F_GAP2:  return fm ? `DVF_FM_GAP2 :
                      perp ? `DVF_PERP_GAP2 : `DVF_MFM_GAP2;
      F_DATA:  return `DVF_SEC_BASE << sz;
      F_GAP3:  return (gap_length == 8'h00) ? `DVF_MARK_LEN : {8'h00, gap_length};
      F_GAP4B: return `DVF_GAP4B_LEN;
      default: return `DVF_MARK_LEN;
    endcase
  endfunction : seg_len

  // ---------------------------------------------------------------
  // ID byte FIFO between host and the format sequencer
  // ---------------------------------------------------------------
  localparam int CW = $clog2(ID_DEPTH) + 1;
  logic          id_out_valid;
  logic          id_pop;
  logic [7:0]    id_byte;
  logic [CW-1:0] id_count;

  dvf_fifo #(
    .W (ID_W),
    .D (ID_DEPTH)
  ) u_id_fifo (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (i_id_valid),
    .o_in_ready  (o_id_ready),
    .i_in_data   (i_id_data),
    .o_out_valid (id_out_valid),
    .i_out_ready (id_pop),
    .o_out_data  (id_byte),
    .o_count     (id_count)
  );

  // ---------------------------------------------------------------
  // Format sequencer
  // ---------------------------------------------------------------
  dvf_fmt_e    fst_q, fst_d;
  logic [15:0] fcnt_q, fcnt_d;
  logic [8:0]  fsec_q, fsec_d;
  logic [15:0] wcrc_q, wcrc_d;
  logic [7:0]  wr_data_q;
  logic        wr_mark_q, wr_gate_q, underrun_q;
  dvf_rec_e    mode_q;
  logic [2:0]  size_q;
  logic [7:0]  gpl_q, fill_q;
  logic        del_q;

  logic        fm, perp, seg_end, sec_last, id_short;
  logic        writing, crc_cov, crc_pre;
  dvf_fmt_e    fst_nxt;
  logic [7:0]  cur_byte;
  logic        cur_mark;

  assign fm       = (mode_q == REC_FM);
  assign perp     = (mode_q == REC_PERP);
  assign seg_end  = (fcnt_q == 16'h0000);
  assign sec_last = (fsec_q == 9'h000);
  assign fst_nxt  = seg_next(fst_q, fm, sec_last);
  assign writing  = (fst_q != F_IDLE) && (fst_q != F_WIDX);
  // Short ID group is caught after the ID mark, before the ID field, never mid-field
  assign id_short = (id_count < CW'(`DVF_ID_NEED));
  assign id_pop   = i_byte_en && (fst_q == F_ID) && id_out_valid;

  // CRC preset during sync so the marks are covered
  assign crc_pre = (fst_q == F_SYNC1) || (fst_q == F_SYNC2);
  assign crc_cov = (fst_q == F_IDAMS) || (fst_q == F_IDAM) ||
                   (fst_q == F_ID) || (fst_q == F_DAMS) ||
                   (fst_q == F_DAM) || (fst_q == F_DATA);

  // Byte chosen for the current slot
  always_comb begin
    cur_mark = 1'b0;
    case (fst_q)
      F_GAP4A, F_GAP1, F_GAP2, F_GAP3, F_GAP4B:
        cur_byte = fm ? `DVF_FM_GAP : `DVF_MFM_GAP;
      F_IAMS: begin
        cur_byte = `DVF_IAM_SYNC;
        cur_mark = 1'b1;
      end
      F_IDAMS, F_DAMS: begin
        cur_byte = `DVF_AM_SYNC;
        cur_mark = 1'b1;
      end
      F_IAM: begin
        cur_byte = `DVF_IAM;
        cur_mark = fm;
      end
      F_IDAM: begin
        cur_byte = `DVF_IDAM;
        cur_mark = fm;
      end
      F_DAM: begin
        cur_byte = del_q ? `DVF_DDAM : `DVF_DAM;
        cur_mark = fm;
      end
      F_ID:    cur_byte = id_byte;
      F_IDCRC, F_DCRC:
        cur_byte = seg_end ? wcrc_q[7:0] : wcrc_q[15:8];
      F_DATA:  cur_byte = fill_q;
      default: cur_byte = `DVF_SYNC_BYTE;
    endcase
  end

  // Next-state logic of the sequencer
  always_comb begin
    fst_d  = fst_q;
    fcnt_d = fcnt_q;
    fsec_d = fsec_q;
    wcrc_d = wcrc_q;
    case (fst_q)
      F_IDLE: begin
        if (i_fmt_start) fst_d = F_WIDX;
      end
      F_WIDX: begin
        if (i_index_pulse) begin
          fst_d  = F_GAP4A;
          fcnt_d = seg_len(F_GAP4A, fm, perp, size_q, gpl_q) - 16'h0001;
        end
      end
      default: begin
        if (i_index_pulse) begin
          fst_d = F_IDLE;
        end else if (i_byte_en) begin
          if (crc_pre) wcrc_d = `DVF_CRC_PRESET;
          else if (crc_cov) wcrc_d = crc_upd(wcrc_q, cur_byte);
          if (!seg_end) begin
            fcnt_d = fcnt_q - 16'h0001;
          end else if (fst_nxt == F_ID && id_short) begin
            fst_d = F_IDLE;
          end else begin
            fst_d  = fst_nxt;
            fcnt_d = seg_len(fst_nxt, fm, perp, size_q, gpl_q)
                     - 16'h0001;
            if (fst_q == F_DCRC) fsec_d = fsec_q - 9'h001;
          end
        end
      end
    endcase
  end

  // Command capture and sequencer state
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      fst_q  <= F_IDLE;
      fcnt_q <= 16'h0000;
      fsec_q <= 9'h000;
      wcrc_q <= `DVF_CRC_PRESET;
      mode_q <= REC_MFM;
      size_q <= 3'h0;
      gpl_q  <= 8'h00;
      fill_q <= 8'h00;
      del_q  <= 1'b0;
    end else begin
      fst_q  <= fst_d;
      fcnt_q <= fcnt_d;
      fsec_q <= fsec_d;
      wcrc_q <= wcrc_d;
      if ((fst_q == F_IDLE) && i_fmt_start) begin
        mode_q <= i_mode;
        size_q <= i_size_code;
        gpl_q  <= i_gap_length;
        fill_q <= i_fill_byte;
        del_q  <= i_deleted;
        fsec_q <= (i_sector_total == 8'h00) ? `DVF_ZERO_TOTAL
                                            : {1'b0, i_sector_total};
      end
    end
  end

  // Registered write stream; gate drops with the terminating index
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wr_data_q  <= 8'h00;
      wr_mark_q  <= 1'b0;
      wr_gate_q  <= 1'b0;
      underrun_q <= 1'b0;
    end else begin
      wr_gate_q <= writing && (fst_d != F_IDLE);
      if (i_byte_en && writing) begin
        wr_data_q <= cur_byte;
        wr_mark_q <= cur_mark;
      end
      if (i_fmt_start && fst_q == F_IDLE) underrun_q <= 1'b0;
      else if (writing && i_byte_en && seg_end &&
               fst_nxt == F_ID && id_short) underrun_q <= 1'b1;
    end
  end

  assign o_wr_data  = wr_data_q;
  assign o_wr_mark  = wr_mark_q;
  assign o_wr_gate  = wr_gate_q;
  assign o_underrun = underrun_q;
  assign o_fmt_busy = (fst_q != F_IDLE);
  // Ask for a full group while too few are waiting
  assign o_id_req   = o_fmt_busy && id_short;

  // ---------------------------------------------------------------
  // Verify engine: data bytes feed only the CRC, never the host
  // ---------------------------------------------------------------
  dvf_vfy_e    vst_q;
  logic [8:0]  vcnt_q;
  logic [15:0] rcrc_q;
  logic        vec_q, vmt_q, side_q;
  logic [7:0]  vlast_q, vspt_q;
  logic        ok_q, crcerr_q, int_q;
  logic        vfy_go, field_end, crc_good, side_end;
  logic        vfy_end, params_ok;
  logic [8:0]  vtotal, remain;

  assign vtotal = (i_sector_total == 8'h00) ? `DVF_ZERO_TOTAL
                                            : {1'b0, i_sector_total};
  // Sectors from the start sector to the side end, plus side one when multi-track
  assign remain = {1'b0, i_sectors_per_side} - {1'b0, i_start_sector}
                  + 9'h001
                  + (i_multi_track ? {1'b0, i_sectors_per_side} : 9'h000);
  assign params_ok = (i_last_sector <= i_sectors_per_side) &&
                     (!i_count_limit_on || vtotal <= remain);
  assign vfy_go    = (vst_q == V_IDLE) && i_vfy_start;
  assign field_end = (vst_q == V_RUN) && i_rd_valid && i_rd_eof;
  // Residue over data plus stored CRC is zero when intact
  assign crc_good  = (crc_upd(rcrc_q, i_rd_data) == 16'h0000);
  assign side_end  = (i_rd_sector == (vec_q ? vspt_q : vlast_q));
  // Only the count or last sector ends it without error; no external count exists
  assign vfy_end   = vec_q ? (vcnt_q == 9'h001)
                           : (side_end && (side_q || !vmt_q));

  // Verify state and running CRC
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      vst_q    <= V_IDLE;
      vcnt_q   <= 9'h000;
      rcrc_q   <= `DVF_CRC_PRESET;
      vec_q    <= 1'b0;
      vmt_q    <= 1'b0;
      side_q   <= 1'b0;
      vlast_q  <= 8'h00;
      vspt_q   <= 8'h00;
      ok_q     <= 1'b0;
      crcerr_q <= 1'b0;
    end else if (vfy_go) begin
      vec_q    <= i_count_limit_on;
      vmt_q    <= i_multi_track;
      side_q   <= i_head;
      vlast_q  <= i_last_sector;
      vspt_q   <= i_sectors_per_side;
      vcnt_q   <= vtotal;
      rcrc_q   <= `DVF_CRC_PRESET;
      crcerr_q <= 1'b0;
      ok_q     <= 1'b0;
      vst_q    <= params_ok ? V_RUN : V_IDLE;
    end else if (vst_q == V_RUN && i_rd_valid) begin
      rcrc_q <= crc_upd(rcrc_q, i_rd_data);
      if (field_end) begin
        rcrc_q <= `DVF_CRC_PRESET;
        vcnt_q <= vcnt_q - 9'h001;
        if (!crc_good) begin
          crcerr_q <= 1'b1;
          vst_q    <= V_IDLE;
        end else if (vfy_end) begin
          ok_q  <= 1'b1;
          vst_q <= V_IDLE;
        end else if (vmt_q && !side_q && side_end) begin
          side_q <= 1'b1;
        end
      end
    end
  end

  // Interrupt on result phase entry; a new event beats the clear
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      int_q <= 1'b0;
    end else if ((vst_q == V_RUN && field_end && (!crc_good || vfy_end))
                 || (vfy_go && !params_ok)
                 || (o_fmt_busy && fst_d == F_IDLE)) begin
      int_q <= 1'b1;
    end else if (i_int_clr) begin
      int_q <= 1'b0;
    end
  end

  assign o_int      = int_q;
  assign o_vfy_busy = (vst_q == V_RUN);
  assign o_vfy_ok   = ok_q;
  assign o_crc_err  = crcerr_q;
  assign o_side     = side_q;
endmodule : dvf_engine

// >>> dv/dvf_drive_model.sv
// Drive model: byte slots, index pulses, recorded read fields.
// Bench calls its tasks; every change lands on the falling edge.
`timescale 1ns/1ps
module dvf_drive_model (
  input  wire logic  i_mclk,
  output logic       o_byte_en = 1'b0,
  output logic       o_index_pulse = 1'b0,
  output logic       o_rd_valid = 1'b0,
  output logic [7:0] o_rd_data = 8'h00,
  output logic       o_rd_eof = 1'b0,
  output logic [7:0] o_rd_sector = 8'h00
);
  // One write slot every second clock
  always @(negedge i_mclk) begin
    o_byte_en <= ~o_byte_en;
  end
  // CCITT step, msb first; caller presets to ones
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction : crc_step
  // Idle data shows the inverse so a stale byte never looks valid
  task automatic put(input logic [7:0] b, input logic eof);
    @(negedge i_mclk);
    {o_rd_valid, o_rd_data, o_rd_eof} = {1'b1, b, eof};
    @(negedge i_mclk);
    {o_rd_valid, o_rd_data, o_rd_eof} = {1'b0, ~b, 1'b0};
  endtask : put
  // Marks, four data bytes, stored CRC; bad corrupts the low CRC byte
  task automatic send_field(input logic [7:0] sec, input logic bad);
    logic [15:0] c;
    logic [7:0]  b;
    c = 16'hFFFF;
    o_rd_sector = sec;
    for (int i = 0; i < 8; i++) begin
      b = (i < 3) ? 8'hA1 : (i == 3) ? 8'hFB : 8'($urandom);
      c = crc_step(c, b);
      put(b, 1'b0);
    end
    put(c[15:8], 1'b0);
    put(c[7:0] ^ {7'h00, bad}, 1'b1);
  endtask : send_field
  task automatic pulse_index();
    @(negedge i_mclk);
    o_index_pulse = 1'b1;
    @(negedge i_mclk);
    o_index_pulse = 1'b0;
  endtask : pulse_index
endmodule : dvf_drive_model

// >>> dv/dvf_engine_assertions.sv
// Port checker for the verify and format engine.
// Bound into dvf_engine; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module dvf_engine_chk (
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic       i_vfy_start,
  input wire logic       i_fmt_start,
  input wire logic [7:0] i_last_sector,
  input wire logic [7:0] i_sectors_per_side,
  input wire logic       i_index_pulse,
  input wire logic       i_rd_eof,
  input wire logic       o_wr_gate,
  input wire logic       o_int,
  input wire logic       o_vfy_busy,
  input wire logic       o_fmt_busy,
  input wire logic       o_vfy_ok,
  input wire logic       o_crc_err,
  input wire logic       o_underrun
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Steps of a format: taken while idle, then index inside the track
  sequence s_fmt_go;
    i_fmt_start && !o_fmt_busy;
  endsequence
  sequence s_track_idx;
    o_fmt_busy && o_wr_gate && i_index_pulse;
  endsequence
  sequence s_vfy_end;
    $fell(o_vfy_busy) && $past(i_rst_n);
  endsequence
  chk_fmt_waits_idx: assert property (
    s_fmt_go |=> o_fmt_busy && !o_wr_gate) else $error("gate early");
  chk_gate_after_idx: assert property (
    $rose(o_wr_gate) |-> $past(i_index_pulse, 2)) else $error("gate cause");
  chk_track_end: assert property (
    s_track_idx |=> !o_fmt_busy && !o_wr_gate && o_int)
    else $error("format end");
  chk_vfy_eof_end: assert property (
    s_vfy_end |-> $past(i_rd_eof)) else $error("verify end cause");
  chk_vfy_int: assert property (
    s_vfy_end |-> o_int) else $error("verify int");
  chk_crc_at_eof: assert property (
    $rose(o_crc_err) |-> $fell(o_vfy_busy) && $past(i_rd_eof))
    else $error("crc flag");
  chk_bad_last: assert property (
    i_vfy_start && !o_vfy_busy && i_last_sector > i_sectors_per_side
    |=> o_int && !o_vfy_busy && !o_vfy_ok) else $error("bad last");
  chk_underrun_stop: assert property (
    $rose(o_underrun) |-> ##[0:1] (!o_fmt_busy && o_int))
    else $error("underrun");
endmodule : dvf_engine_chk
bind dvf_engine dvf_engine_chk chk_u (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_vfy_start(i_vfy_start),
  .i_fmt_start(i_fmt_start), .i_last_sector(i_last_sector),
  .i_sectors_per_side(i_sectors_per_side), .i_rd_eof(i_rd_eof),
  .i_index_pulse(i_index_pulse), .o_wr_gate(o_wr_gate), .o_int(o_int),
  .o_vfy_busy(o_vfy_busy), .o_fmt_busy(o_fmt_busy), .o_vfy_ok(o_vfy_ok),
  .o_crc_err(o_crc_err), .o_underrun(o_underrun));

// >>> dv/disk_verify_and_track_format_bench.sv
// Self-checking bench: verify runs and track formats in all modes.
// Drives inputs on the falling edge; drive model supplies disk side.
`timescale 1ns/1ps
module disk_verify_and_track_format_bench;
  import dvf_pkg::*;
  logic       i_mclk = 1'b0, i_rst_n, i_vfy_start, i_fmt_start, i_head;
  logic       i_count_limit_on, i_multi_track, i_deleted, i_int_clr;
  logic       i_id_valid, i_byte_en, i_index_pulse, i_rd_valid, i_rd_eof;
  logic       o_id_ready, o_id_req, o_wr_gate, o_wr_mark, o_side, o_int;
  logic       o_vfy_busy, o_fmt_busy, o_vfy_ok, o_crc_err, o_underrun;
  logic [7:0] i_sector_total, i_last_sector, i_start_sector, i_gap_length;
  logic [7:0] i_sectors_per_side, i_fill_byte, i_id_data, i_rd_data;
  logic [7:0] i_rd_sector, o_wr_data;
  logic [2:0] i_size_code;
  dvf_rec_e   i_mode;
  logic       en_q = 1'b0;
  logic [7:0] wl[$];
  logic       ml[$];
  int         num_errors = 0, cmp_count = 0, cyc = 0;
  always #2 i_mclk = ~i_mclk;
  dvf_engine dut_u (.*);
  dvf_drive_model drv_u (.i_mclk(i_mclk), .o_byte_en(i_byte_en),
    .o_index_pulse(i_index_pulse), .o_rd_valid(i_rd_valid),
    .o_rd_data(i_rd_data), .o_rd_eof(i_rd_eof), .o_rd_sector(i_rd_sector));
  // Log each written byte; a hang is cut short by the cycle ceiling
  always @(posedge i_mclk) begin
    if (en_q && o_wr_gate) begin
      wl.push_back(o_wr_data);
      ml.push_back(o_wr_mark);
    end
    en_q <= i_byte_en;
    cyc  <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [23:0] s, e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : check
  // Fields a verify should read before ending; zero means refused
  function automatic int vfy_len(logic l, m, logic [7:0] t, e, s, p);
    if (e > p) return 0;
    if (l) return (((t == 0) ? 256 : t) > (p - s + 1 + (m ? p : 0))) ? 0 :
                  ((t == 0) ? 256 : t);
    return e - s + 1 + (m ? e : 0);
  endfunction : vfy_len
  task automatic run_vfy(input logic l, m, input logic [7:0] t, e, s, p,
                         input int bad);
    int         n;
    logic [7:0] sec, w;
    logic       sd;
    {n, sec, sd, w} = {vfy_len(l, m, t, e, s, p), s, 1'b0, l ? p : e};
    @(negedge i_mclk);
    {i_count_limit_on, i_multi_track, i_sector_total} = {l, m, t};
    {i_last_sector, i_start_sector, i_sectors_per_side} = {e, s, p};
    {i_int_clr, i_vfy_start} = 2'h2;
    @(negedge i_mclk);
    {i_int_clr, i_vfy_start} = 2'h1;
    @(negedge i_mclk);
    i_vfy_start = 1'b0;
    check("busy", o_vfy_busy, n != 0);
    for (int k = 1; k <= n && k <= bad; k++) begin
      drv_u.send_field(sec, k == bad);
      sd  = sd | (m && sec == w);
      sec = (sec == w) ? 8'h01 : sec + 8'h01;
      check("side", o_side, sd);
      check("busy", o_vfy_busy, k < n && k != bad);
    end
    check("ok", o_vfy_ok, n != 0 && bad > n);
    check("crc", o_crc_err, bad <= n);
    check("int", o_int, 1'b1);
  endtask : run_vfy
  task automatic run_fmt(input int m, n);
    logic [7:0]  id[$];
    logic [15:0] c;
    logic [7:0]  gp, mk;
    int          s, p, g4, hdr, idp, dp, sl, o;
    {gp, g4, s, p} = (m == 1) ? {8'hFF, 32'd40, 32'd6, 32'd0}
                              : {8'h4E, 32'd80, 32'd12, 32'd3};
    hdr = g4 + s + p + 1 + ((m == 1) ? 26 : 50);
    idp = hdr + s + p + 1;
    dp  = idp + 6 + ((m == 1) ? 11 : (m == 2) ? 41 : 22) + s + p + 1;
    sl  = dp + 214 - hdr;
    wl.delete();
    ml.delete();
    @(negedge i_mclk);
    i_mode = dvf_rec_e'(m);
    {i_fill_byte, i_deleted} = {8'($urandom), 1'($urandom)};
    {i_sector_total, i_gap_length} = {8'(n), 8'h54};
    {i_int_clr, i_fmt_start} = 2'h2;
    mk = i_deleted ? 8'hF8 : 8'hFB;
    @(negedge i_mclk);
    {i_int_clr, i_fmt_start} = 2'h1;
    @(negedge i_mclk);
    i_fmt_start = 1'b0;
    check("idreq", o_id_req, 1'b1);
    for (int k = 0; k < 4 * n; k++) begin
      id.push_back((k % 4 == 2) ? 8'(9 - k / 4) : 8'($urandom));
      @(negedge i_mclk);
      {i_id_valid, i_id_data} = {1'b1, id[k]};
      @(negedge i_mclk);
      i_id_valid = 1'b0;
    end
    check("ready", o_id_ready, n < 4);
    repeat (8) @(negedge i_mclk);
    check("gate", o_wr_gate, 1'b0);
    drv_u.pulse_index();
    for (int t = 0; t < 9000 && o_fmt_busy &&
         (n == 0 || wl.size() <= hdr + n * sl); t++)
      @(negedge i_mclk);
    check("under", o_underrun, n == 0);
    if (n == 0) return;
    drv_u.pulse_index();
    repeat (4) @(negedge i_mclk);
    check("fbusy", {o_fmt_busy, o_wr_gate, o_int}, 3'h1);
    check("gap4a", {wl[0], wl[g4], wl[g4 + s + p]}, {gp, 16'h00FC});
    check("mark", {ml[g4+s], ml[g4+s+p]}, {1'b1, p == 0});
    for (int j = 0; j < n; j++) begin
      o = j * sl;
      c = 16'hFFFF;
      repeat (p) c = drv_u.crc_step(c, 8'hA1);
      c = drv_u.crc_step(c, 8'hFE);
      for (int b = 0; b < 4; b++) begin
        c = drv_u.crc_step(c, id[4 * j + b]);
        check("id", wl[o + idp + b], id[4 * j + b]);
      end
      check("idcrc", {wl[o + idp + 4], wl[o + idp + 5]}, c);
      check("dam", wl[o + dp - 1], mk);
      c = 16'hFFFF;
      repeat (p) c = drv_u.crc_step(c, 8'hA1);
      c = drv_u.crc_step(c, mk);
      for (int b = 0; b < 128; b++) begin
        c = drv_u.crc_step(c, i_fill_byte);
        check("fill", wl[o + dp + b], i_fill_byte);
      end
      check("dcrc", {wl[o + dp + 128], wl[o + dp + 129]}, c);
      check("gap3", {wl[o + dp + 213], wl[o + dp + 214]},
            {gp, (j < n - 1) ? 8'h00 : gp});
    end
  endtask : run_fmt
  initial begin
    {i_rst_n, i_vfy_start, i_fmt_start, i_head, i_id_valid} = '0;
    {i_count_limit_on, i_multi_track, i_deleted, i_int_clr} = '0;
    {i_sector_total, i_last_sector, i_start_sector, i_gap_length} = '0;
    {i_sectors_per_side, i_fill_byte, i_id_data, i_size_code} = '0;
    i_mode = REC_MFM;
    repeat (4) @(negedge i_mclk);
    i_rst_n = 1'b1;
    void'($urandom(94318));
    check("reset", {o_id_ready, o_int, o_vfy_busy, o_wr_gate}, 4'h8);
    run_vfy(1'b0, 1'b0, 8'hFF, 8'h03, 8'h01, 8'h09, 99);
    run_vfy(1'b0, 1'b0, 8'hFF, 8'h05, 8'h01, 8'h09, 2);
    run_vfy(1'b1, 1'b0, 8'($urandom_range(9, 1)), 8'h09, 8'h01, 8'h09, 99);
    run_vfy(1'b0, 1'b1, 8'hFF, 8'h0A, 8'h01, 8'h09, 99);
    run_vfy(1'b1, 1'b0, 8'h00, 8'h09, 8'h01, 8'h09, 99);
    run_vfy(1'b0, 1'b1, 8'hFF, 8'h03, 8'h02, 8'h09, 99);
    run_vfy(1'b1, 1'b1, 8'h04, 8'h09, 8'h08, 8'h09, 99);
    run_vfy(1'b1, 1'b1, 8'h00, 8'hFF, 8'h01, 8'hFF, 999);
    for (int m = 0; m < 3; m++) run_fmt(m, (m == 0) ? 4 : 1);
    run_fmt(0, 0);
    final_report();
  end
endmodule : disk_verify_and_track_format_bench
